// ---- rtl/rps_sequencer.sv ----
`timescale 1ns/1ps
// What this block does
// - Ten strobes, nine delays of 2 to 5 ms
// - Power-up fires strobe one, then steps upward
// - Assignments and delays held in writable registers
// - Off state wakes on edges or adapter grounded with main supply present
// - Pre-off state wakes on edges only, enable rise included
// - Suspend wakes on edges or enable level
// - Wake enters wait state and starts power-up
// - Wait holds while enable low, button/adapter low
// - Wait times out after 20 s into power-down
// - Enable moves wait to active, adapter ignored
// - Unassigned rails keep their present condition
// - Enable register blocked while sequencer runs
// - Enable bits show real rail state, read as zero while sequencer runs
// - Power-down runs strobe ten back to one
// - Power-down ends 500 ms after it starts
// - Enable low in active starts power-down
// - Long button press powers down
module rps_sequencer
  import rps_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Wake and fault inputs
  input wire logic push_button_input,
  input wire logic adapter_detect_input,
  input wire logic host_power_enable,
  input wire logic main_supply_present,
  input wire logic undervoltage_lockout,
  input wire logic overtemperature_shutdown,
  // Rail control
  output logic [rps_pkg::NUM_RAILS-1:0] rail_enable,
  output logic [rps_pkg::NUM_RAILS-1:0] rail_discharge,
  output rps_pkg::rps_state_t power_state,
  output logic seq_busy
);
  import rps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Tick and edges
  logic tick;
  logic [2:0] fall;
  logic [2:0] rise;

  rps_ms_tick #(.TICK_CYCLES(TICK_CYCLES_P)) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick)
  );

  rps_edge_detect #(.W(3)) u_edge (
    .ref_clk(ref_clk),
    .rst(rst),
    .level({host_power_enable, adapter_detect_input, push_button_input}),
    .fall(fall),
    .rise(rise)
  );

  logic pb_fall, ac_fall, en_rise, no_fault;
  assign pb_fall = fall[0];
  assign ac_fall = fall[1];
  assign en_rise = rise[2];
  assign no_fault = !undervoltage_lockout && !overtemperature_shutdown;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [3:0] assign_reg [NUM_RAILS];
  logic [3:0] assign_next [NUM_RAILS];
  logic [1:0] dly_reg [NUM_DELAYS];
  logic [1:0] dly_next [NUM_DELAYS];
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] rd_next;

  // Delay in ticks, plus one so a partial first tick never shortens it
  function automatic logic [6:0] delay_ticks(input logic [1:0] code,
                                             input logic down,
                                             input logic mul);
    logic [6:0] ms;
    ms = 7'(DELAY_MIN_MS) + {5'h00, code};
    if (down && mul) begin
      ms = 7'(ms * PDN_DELAY_FACTOR);
    end
    delay_ticks = ms + 7'h01;
  endfunction : delay_ticks

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  logic busy_reg, busy_next, down_reg, down_next, fire_reg, fire_next;
  logic [3:0] strobe_reg, strobe_next;
  logic [6:0] dcnt_reg, dcnt_next;
  logic [9:0] pdn_ms_reg, pdn_ms_next;
  logic pdn_done;
  logic start_up, start_dn;

  assign pdn_done = down_reg && busy_reg
                    && pdn_ms_reg == 10'(PDN_LIMIT_MS + 1);

  always_comb begin
    busy_next = busy_reg;
    down_next = down_reg;
    fire_next = 1'b0;
    strobe_next = strobe_reg;
    dcnt_next = dcnt_reg;
    pdn_ms_next = pdn_ms_reg;
    if (start_dn) begin
      busy_next = 1'b1;
      down_next = 1'b1;
      fire_next = 1'b1;
      strobe_next = LAST_STROBE;
      dcnt_next = delay_ticks(dly_reg[NUM_DELAYS-1], 1'b1,
                              ctrl_reg[CTRL_DLYMUL_BIT]);
      pdn_ms_next = 10'h000;
    end else if (start_up) begin
      busy_next = 1'b1;
      down_next = 1'b0;
      fire_next = 1'b1;
      strobe_next = FIRST_STROBE;
      dcnt_next = delay_ticks(dly_reg[0], 1'b0, 1'b0);
    end else if (pdn_done) begin
      busy_next = 1'b0;
    end else if (busy_reg && tick) begin
      if (down_reg) begin
        pdn_ms_next = pdn_ms_reg + 10'h001;
      end
      if (dcnt_reg > 7'h01) begin
        dcnt_next = dcnt_reg - 7'h01;
      end else if (!down_reg) begin
        strobe_next = strobe_reg + 4'h1;
        fire_next = 1'b1;
        if (strobe_reg + 4'h1 == LAST_STROBE) begin
          busy_next = 1'b0;
        end else begin
          dcnt_next = delay_ticks(dly_reg[strobe_reg], 1'b0, 1'b0);
        end
      end else if (strobe_reg > FIRST_STROBE) begin
        strobe_next = strobe_reg - 4'h1;
        fire_next = 1'b1;
        dcnt_next = 7'h00;
        if (strobe_reg > 4'h2) begin
          dcnt_next = delay_ticks(dly_reg[strobe_reg - 4'h3], 1'b1,
                                  ctrl_reg[CTRL_DLYMUL_BIT]);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      down_reg <= 1'b0;
      fire_reg <= 1'b0;
      strobe_reg <= NO_STROBE;
      dcnt_reg <= 7'h00;
      pdn_ms_reg <= 10'h000;
    end else begin
      busy_reg <= busy_next;
      down_reg <= down_next;
      fire_reg <= fire_next;
      strobe_reg <= strobe_next;
      dcnt_reg <= dcnt_next;
      pdn_ms_reg <= pdn_ms_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine
  rps_state_t state_reg, state_next, target_reg, target_next;
  logic [14:0] wait_ms_reg, wait_ms_next;
  logic [13:0] press_ms_reg, press_ms_next;
  logic long_press, wait_expired, btn_states;

  assign btn_states = state_reg inside {ST_WAIT_FOR_ENABLE, ST_ACTIVE,
                                        ST_SUSPEND};
  assign long_press = ctrl_reg[CTRL_LONGSEL_BIT] ?
    press_ms_reg > 14'(LONG_PRESS_ALT_MS) : press_ms_reg > 14'(LONG_PRESS_MS);
  assign wait_expired = wait_ms_reg >= 15'(WAIT_TIMEOUT_MS);

  always_comb begin
    state_next = state_reg;
    target_next = target_reg;
    start_up = 1'b0;
    start_dn = 1'b0;
    wait_ms_next = 15'h0000;
    press_ms_next = 14'h0000;
    if (btn_states && !push_button_input) begin
      press_ms_next = press_ms_reg + {13'h0000, tick && !long_press};
    end
    unique case (state_reg)
      ST_OFF: begin
        if (no_fault && (pb_fall || ac_fall || en_rise
            || (main_supply_present && !adapter_detect_input))) begin
          start_up = 1'b1;
        end
      end
      ST_PRE_OFF: begin
        start_up = no_fault && (pb_fall || ac_fall || en_rise);
      end
      ST_SUSPEND: begin
        if (!no_fault || long_press) begin
          start_dn = 1'b1;
          target_next = ST_OFF;
        end else if (pb_fall || ac_fall || host_power_enable) begin
          start_up = 1'b1;
        end
      end
      ST_WAIT_FOR_ENABLE: begin
        wait_ms_next = wait_ms_reg + {14'h0000, tick && !wait_expired};
        if (!no_fault || long_press) begin
          start_dn = 1'b1;
          target_next = ST_OFF;
        end else if (host_power_enable) begin
          state_next = ST_ACTIVE;
        end else if (push_button_input && adapter_detect_input
                     && wait_expired) begin
          start_dn = 1'b1;
          target_next = ST_OFF;
        end
      end
      ST_ACTIVE: begin
        if (!no_fault || long_press) begin
          start_dn = 1'b1;
          target_next = ST_OFF;
        end else if (!host_power_enable) begin
          start_dn = 1'b1;
          target_next = ctrl_reg[CTRL_SUSPEND_BIT] ? ST_SUSPEND : ST_PRE_OFF;
        end
      end
      ST_PWRDN: begin
        if (pdn_done) begin
          state_next = target_reg;
        end
      end
    endcase
    if (start_up) begin
      state_next = ST_WAIT_FOR_ENABLE;
    end
    if (start_dn) begin
      state_next = ST_PWRDN;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_OFF;
      target_reg <= ST_OFF;
      wait_ms_reg <= 15'h0000;
      press_ms_reg <= 14'h0000;
    end else begin
      state_reg <= state_next;
      target_reg <= target_next;
      wait_ms_reg <= wait_ms_next;
      press_ms_reg <= press_ms_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and rail enables
  logic [NUM_RAILS-1:0] en_reg, en_next, dis_reg, dis_next;
  logic en_locked, en_write;

  // Last up-strobe clears busy while its fire is pending, so both lock
  assign en_locked = busy_reg || fire_reg;
  assign en_write = reg_wr && reg_addr == OFS_RAIL_EN && !en_locked;

  always_comb begin
    assign_next = assign_reg;
    dly_next = dly_reg;
    ctrl_next = ctrl_reg;
    en_next = en_reg;
    dis_next = dis_reg;
    rd_next = 8'h00;
    if (reg_wr && reg_addr inside {[OFS_ASSIGN0:OFS_ASSIGN3]}) begin
      assign_next[2*(reg_addr - OFS_ASSIGN0)] = reg_wdata[3:0];
      assign_next[2*(reg_addr - OFS_ASSIGN0) + 1] = reg_wdata[7:4];
    end
    if (reg_wr && reg_addr inside {[OFS_DELAY0:OFS_DELAY2]}) begin
      for (int k = 0; k < 4; k++) begin
        if (4*(reg_addr - OFS_DELAY0) + k < NUM_DELAYS) begin
          dly_next[4*(reg_addr - OFS_DELAY0) + k] = reg_wdata[2*k +: 2];
        end
      end
    end
    if (reg_wr && reg_addr == OFS_CTRL) begin
      ctrl_next = reg_wdata;
    end
    if (en_write) begin
      en_next = reg_wdata;
      dis_next = dis_reg & ~reg_wdata;
    end
    for (int r = 0; r < NUM_RAILS; r++) begin
      // Strobe is never zero, so unassigned rails never match
      if (fire_reg && assign_reg[r] == strobe_reg) begin
        en_next[r] = !down_reg;
        dis_next[r] = down_reg;
      end
    end
    if (reg_rd) begin
      unique case (reg_addr) inside
        OFS_RAIL_EN: rd_next = en_locked ? 8'h00 : en_reg;
        [OFS_ASSIGN0:OFS_ASSIGN3]:
          rd_next = {assign_reg[2*(reg_addr - OFS_ASSIGN0) + 1],
                     assign_reg[2*(reg_addr - OFS_ASSIGN0)]};
        [OFS_DELAY0:OFS_DELAY2]: begin
          for (int k = 0; k < 4; k++) begin
            if (4*(reg_addr - OFS_DELAY0) + k < NUM_DELAYS) begin
              rd_next[2*k +: 2] = dly_reg[4*(reg_addr - OFS_DELAY0) + k];
            end
          end
        end
        OFS_CTRL: rd_next = ctrl_reg;
        OFS_STATUS: rd_next = {busy_reg, down_reg, state_reg};
        OFS_STROBE: rd_next = {4'h0, strobe_reg};
        default: rd_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int r = 0; r < NUM_RAILS; r++) begin
        assign_reg[r] <= RST_ASSIGN[4*r +: 4];
      end
      for (int d = 0; d < NUM_DELAYS; d++) begin
        dly_reg[d] <= RST_DELAY[2*d +: 2];
      end
      ctrl_reg <= RST_CTRL;
      en_reg <= RST_RAIL_EN;
      dis_reg <= '0;
      reg_rdata <= 8'h00;
    end else begin
      assign_reg <= assign_next;
      dly_reg <= dly_next;
      ctrl_reg <= ctrl_next;
      en_reg <= en_next;
      dis_reg <= dis_next;
      reg_rdata <= rd_next;
    end
  end

  assign rail_enable = en_reg;
  assign rail_discharge = dis_reg;
  assign power_state = state_reg;
  assign seq_busy = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_up_first_strobe: assert property (
    start_up && !start_dn |=> fire_reg && strobe_reg == 4'h1 && !down_reg)
    else $error("power-up did not fire strobe one");
  a_dn_first_strobe: assert property (
    start_dn |=> fire_reg && strobe_reg == 4'ha && down_reg)
    else $error("power-down did not fire strobe ten");
  a_off_wake: assert property (
    state_reg == ST_OFF && no_fault && pb_fall
    |=> state_reg == ST_WAIT_FOR_ENABLE && fire_reg)
    else $error("off state missed a button wake");
  a_pre_off_wake: assert property (
    state_reg == ST_PRE_OFF && no_fault && en_rise
    |=> state_reg == ST_WAIT_FOR_ENABLE)
    else $error("pre-off state missed an enable wake");
  a_suspend_level: assert property (
    state_reg == ST_SUSPEND && no_fault && !long_press && host_power_enable
    |=> state_reg == ST_WAIT_FOR_ENABLE)
    else $error("suspend ignored enable level");
  a_wait_hold: assert property (
    state_reg == ST_WAIT_FOR_ENABLE && no_fault && !long_press
    && !host_power_enable && !(push_button_input && adapter_detect_input)
    |=> state_reg == ST_WAIT_FOR_ENABLE)
    else $error("wait state left too early");
  a_wait_timeout: assert property (
    state_reg == ST_WAIT_FOR_ENABLE && !host_power_enable
    && push_button_input && adapter_detect_input && wait_expired
    |=> state_reg == ST_PWRDN ##0 target_reg == ST_OFF)
    else $error("wait timeout did not power down");
  a_active_drop: assert property (
    state_reg == ST_ACTIVE && !host_power_enable |=> state_reg == ST_PWRDN)
    else $error("enable drop did not power down");
  a_rail_untouched: assert property (
    fire_reg && assign_reg[1] == NO_STROBE |=> $stable(en_reg[1]))
    else $error("unassigned rail changed");
  a_rail_follows: assert property (
    fire_reg && assign_reg[0] == strobe_reg
    |=> en_reg[0] == !$past(down_reg))
    else $error("rail enable bit disagrees with strobe");
  a_enable_locked: assert property (
    reg_wr && reg_addr == OFS_RAIL_EN && en_locked && !fire_reg
    |=> $stable(en_reg))
    else $error("enable register written while running");
  a_pdn_bound: assert property (
    start_dn |=> busy_reg && down_reg throughout pdn_ms_reg == 10'h000 [*1])
    else $error("power-down did not start its limit timer");

  c_full_up: cover property (fire_reg && !down_reg && strobe_reg == 4'ha);
  c_full_down: cover property (fire_reg && down_reg && strobe_reg == 4'h1);
  c_active: cover property (state_reg == ST_ACTIVE);
  c_suspend: cover property (
    state_reg == ST_PWRDN ##1 state_reg == ST_SUSPEND);
endmodule : rps_sequencer

// ---- rtl/rps_pkg.sv ----
package rps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_RAILS = 8;
  localparam int NUM_DELAYS = 9;
  localparam logic [3:0] LAST_STROBE = 4'ha;
  localparam logic [3:0] FIRST_STROBE = 4'h1;
  localparam logic [3:0] NO_STROBE = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [3:0] OFS_RAIL_EN = 4'h0;
  localparam logic [3:0] OFS_ASSIGN0 = 4'h1;
  localparam logic [3:0] OFS_ASSIGN3 = 4'h4;
  localparam logic [3:0] OFS_DELAY0 = 4'h5;
  localparam logic [3:0] OFS_DELAY2 = 4'h7;
  localparam logic [3:0] OFS_CTRL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'h9;
  localparam logic [3:0] OFS_STROBE = 4'ha;

  // Control fields
  localparam int CTRL_DLYMUL_BIT = 0;
  localparam int CTRL_LONGSEL_BIT = 1;
  localparam int CTRL_SUSPEND_BIT = 2;

  // Reset values
  localparam logic [7:0] RST_RAIL_EN = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [31:0] RST_ASSIGN = 32'ha987_6543;
  localparam logic [17:0] RST_DELAY = 18'h0_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DELAY_MIN_MS = 2;
  localparam int DELAY_MAX_MS = 5;
  localparam int PDN_DELAY_FACTOR = 10;
  localparam int WAIT_TIMEOUT_MS = 20000;
  localparam int LONG_PRESS_MS = 8000;
  localparam int LONG_PRESS_ALT_MS = 15000;
  localparam int PDN_LIMIT_MS = 500;

  ////////////////////////////////////////////////////////////////////////////
  // Power states
  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_PRE_OFF = 6'h02,
    ST_SUSPEND = 6'h04,
    ST_WAIT_FOR_ENABLE = 6'h08,
    ST_ACTIVE = 6'h10,
    ST_PWRDN = 6'h20
  } rps_state_t;

endpackage : rps_pkg

// ---- rtl/rps_ms_tick.sv ----
`timescale 1ns/1ps
module rps_ms_tick #(
  parameter int TICK_CYCLES = 50000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Millisecond enable
  output logic tick
);
  logic [16:0] cnt_reg;
  logic [16:0] cnt_next;
  logic tick_next;

  always_comb begin
    tick_next = 1'b0;
    cnt_next = cnt_reg + 17'h0_0001;
    if (cnt_reg == 17'(TICK_CYCLES - 1)) begin
      cnt_next = 17'h0_0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 17'h0_0000;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick <= tick_next;
    end
  end
endmodule : rps_ms_tick

// ---- rtl/rps_edge_detect.sv ----
`timescale 1ns/1ps
module rps_edge_detect #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Levels in, edges out
  input wire logic [W-1:0] level,
  output logic [W-1:0] fall,
  output logic [W-1:0] rise
);
  // Held high at reset so an idle-high pin gives no false press
  logic [W-1:0] prev_reg;
  logic [W-1:0] prev_next;

  always_comb begin
    prev_next = level;
    fall = prev_reg & ~level;
    rise = ~prev_reg & level;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_reg <= '1;
    end else begin
      prev_reg <= prev_next;
    end
  end
endmodule : rps_edge_detect

// ---- test/rps_host_model.sv ----
`timescale 1ns/1ps
module rps_host_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Commands from the bench
  input wire logic press_req,
  input wire logic [15:0] press_len,
  input wire logic en_req,
  input wire logic [7:0] en_lat,
  // Pins toward the sequencer
  output logic push_button_input,
  output logic host_power_enable
);
  logic [15:0] press_cnt;
  logic [7:0] lat_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Button idles high on its pull-up, low only while held
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      press_cnt <= 16'h0000;
      push_button_input <= 1'b1;
    end else if (press_req) begin
      press_cnt <= press_len;
      push_button_input <= 1'b0;
    end else if (press_cnt > 16'h0001) begin
      press_cnt <= press_cnt - 16'h0001;
    end else begin
      press_cnt <= 16'h0000;
      push_button_input <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable follows the request after a firmware latency, far below 20 s
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lat_cnt <= 8'h00;
      host_power_enable <= 1'b0;
    end else if (en_req == host_power_enable) begin
      lat_cnt <= 8'h00;
    end else if (lat_cnt >= en_lat) begin
      lat_cnt <= 8'h00;
      host_power_enable <= en_req;
    end else begin
      lat_cnt <= lat_cnt + 8'h01;
    end
  end
endmodule : rps_host_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import rps_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic adapter_detect_input = 1'b1;
  logic main_supply_present = 1'b0;
  logic undervoltage_lockout = 1'b0;
  logic overtemperature_shutdown = 1'b0;
  logic push_button_input;
  logic host_power_enable;
  logic press_req = 1'b0;
  logic [15:0] press_len = 16'h0028;
  logic en_req = 1'b0;
  logic [7:0] en_lat = 8'h00;
  logic [NUM_RAILS-1:0] rail_enable;
  logic [NUM_RAILS-1:0] rail_discharge;
  rps_state_t power_state;
  logic seq_busy;
  logic [7:0] rd_val;
  int miscompares = 0;
  int check_count = 0;
  int n;
  time t0;
  int adr[7] = '{5, 6, 7, 8, 9, 11, 0};

  // Short tick keeps the 20 s wait and the long press inside the run
  rps_sequencer #(.TICK_CYCLES_P(2)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .push_button_input(push_button_input),
    .adapter_detect_input(adapter_detect_input),
    .host_power_enable(host_power_enable),
    .main_supply_present(main_supply_present),
    .undervoltage_lockout(undervoltage_lockout),
    .overtemperature_shutdown(overtemperature_shutdown),
    .rail_enable(rail_enable), .rail_discharge(rail_discharge),
    .power_state(power_state), .seq_busy(seq_busy));

  rps_host_model i_host (
    .ref_clk(ref_clk), .rst(rst), .press_req(press_req),
    .press_len(press_len), .en_req(en_req), .en_lat(en_lat),
    .push_button_input(push_button_input),
    .host_power_enable(host_power_enable));

  always #10 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic wait_st(input logic [5:0] s, input int k);
    for (int i = 0; i < k && power_state !== s; i++) step(1);
    chk({2'h0, power_state}, {2'h0, s});
  endtask : wait_st

  task automatic press(input logic [15:0] len);
    @(posedge ref_clk);
    press_len <= len;
    press_req <= 1'b1;
    @(posedge ref_clk);
    press_req <= 1'b0;
  endtask : press

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    step(1);
    for (int a = 1; a <= 4; a++) begin
      rd(4'(a), rd_val);
      chk(rd_val, RST_ASSIGN[8*a-8 +: 8]);
    end
    foreach (adr[i]) begin
      rd(4'(adr[i]), rd_val);
      chk(rd_val, (adr[i] == 9) ? 8'h01 : 8'h00);
    end
    $display("test reset_values done");
    // Rail0 on strobe 1, rail1 left to software, delays 1..4 at 5 ms
    wr(OFS_ASSIGN0, 8'h01);
    wr(OFS_DELAY0, 8'hff);
    wr(OFS_RAIL_EN, 8'h02);
    rd(OFS_DELAY0, rd_val);
    chk(rd_val, 8'hff);
    step(1);
    chk(rail_enable, 8'h02);
    press(16'h0028);
    wait_st(ST_WAIT_FOR_ENABLE, 5);
    t0 = $time;
    step(10);
    chk({2'h0, power_state}, 8'h08);
    wr(OFS_RAIL_EN, 8'h00);
    rd(OFS_RAIL_EN, rd_val);
    chk(rd_val, 8'h00);
    for (int i = 0; i < 500 && seq_busy !== 1'b0; i++) step(1);
    n = int'(($time - t0) / 20);
    chk({7'h0, n >= 60 && n <= 80}, 8'h01);
    // Strobe ten fires as busy drops; its rails follow a cycle later
    step(1);
    chk(rail_enable, 8'hff);
    rd(OFS_RAIL_EN, rd_val);
    chk(rd_val, 8'hff);
    rd(OFS_STROBE, rd_val);
    chk(rd_val, 8'h0a);
    $display("test power_up done");
    // Slow host answer, then an adapter pulse that active must ignore
    en_lat <= 8'h1e;
    en_req <= 1'b1;
    wait_st(ST_ACTIVE, 60);
    @(posedge ref_clk);
    adapter_detect_input <= 1'b0;
    step(5);
    adapter_detect_input <= 1'b1;
    step(5);
    rd(OFS_STATUS, rd_val);
    chk(rd_val, 8'h10);
    en_lat <= 8'h00;
    en_req <= 1'b0;
    wait_st(ST_PWRDN, 5);
    t0 = $time;
    for (int i = 0; i < 100 && rail_enable[7] !== 1'b0; i++) step(1);
    chk({7'h0, rail_enable[0]}, 8'h01);
    wait_st(ST_PRE_OFF, 5200);
    n = int'(($time - t0) / 20);
    chk({7'h0, n >= 998 && n <= 1006}, 8'h01);
    chk(rail_discharge, 8'hfd);
    chk(rail_enable, 8'h02);
    $display("test power_down done");
    wr(OFS_CTRL, 8'h04);
    en_req <= 1'b1;
    wait_st(ST_WAIT_FOR_ENABLE, 10);
    wait_st(ST_ACTIVE, 600);
    en_req <= 1'b0;
    wait_st(ST_SUSPEND, 5300);
    chk(rail_enable, 8'h02);
    @(posedge ref_clk);
    en_req <= 1'b1;
    wait_st(ST_WAIT_FOR_ENABLE, 10);
    wait_st(ST_ACTIVE, 600);
    $display("test suspend done");
    @(posedge ref_clk);
    overtemperature_shutdown <= 1'b1;
    wait_st(ST_PWRDN, 5);
    en_req <= 1'b0;
    wait_st(ST_OFF, 5300);
    undervoltage_lockout <= 1'b1;
    overtemperature_shutdown <= 1'b0;
    press(16'h0008);
    step(20);
    chk({2'h0, power_state}, 8'h01);
    adapter_detect_input <= 1'b0;
    main_supply_present <= 1'b1;
    step(5);
    chk({2'h0, power_state}, 8'h01);
    undervoltage_lockout <= 1'b0;
    wait_st(ST_WAIT_FOR_ENABLE, 5);
    $display("test faults done");
    // Adapter and button high, enable low: wait must time out
    t0 = $time;
    adapter_detect_input <= 1'b1;
    wait_st(ST_PWRDN, 40100);
    n = int'(($time - t0) / 20);
    chk({7'h0, n >= 2 * WAIT_TIMEOUT_MS}, 8'h01);
    wait_st(ST_OFF, 1100);
    press(16'h41a0);
    wait_st(ST_WAIT_FOR_ENABLE, 5);
    t0 = $time;
    wait_st(ST_PWRDN, 16100);
    n = int'(($time - t0) / 20);
    chk({7'h0, n >= 2 * LONG_PRESS_MS}, 8'h01);
    wait_st(ST_OFF, 1100);
    $display("test long_waits done");
    summarize();
  end

  // Tests need about 62000 cycles
  initial begin
    #(70000 * 20);
    miscompares++;
    summarize();
  end
endmodule : tb_top
